// ==== pin_irq_pkg.sv ====
// Package for the keyboard pin interrupt unit: register map and constants
// How it works
// RULE1 - Each set pin enable bit makes that pin an interrupt source.
// RULE2 - Polarity bit 0 means falling or low; 1 means rising or high.
// RULE3 - One mode bit sets edge-only or edge-and-level for all pins.
// RULE4 - Falling edge is a sample of 1 followed by 0 next cycle.
// RULE5 - Rising edge is a sample of 0 followed by 1 next cycle.
// RULE6 - After an edge, all enabled pins must deassert before re-arming.
// RULE7 - In edge mode a valid edge sets the shared flag.
// RULE8 - Flag and interrupt enable both high raise the request.
// RULE9 - Writing 1 to acknowledge clears the flag; nothing else does.
// RULE10 - In level mode an edge or asserted level sets the flag.
// RULE11 - In level mode acknowledge fails while any enabled pin asserts.
// RULE12 - Polarity bit picks pull-up at 0, pull-down at 1.
// RULE13 - A false flag on first enabling a pin is not suppressed.
// RULE14 - Software masks, sets polarity, pulls, enables, acks, then unmasks.
// RULE15 - Each pin enable bit acts alone without touching the others.
// RULE16 - Flag is read-only; acknowledge bit always reads 0.
// RULE17 - Mode bit 0 is edge-only, 1 is edge-and-level.
// RULE18 - Upper four bits of status/control read as 0.
// RULE19 - Event in the same cycle as acknowledge keeps the flag set.
package pin_irq_pkg;
  localparam logic [7:0] ADDR_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_PIN_ENABLE = 8'h04;
  localparam logic [7:0] ADDR_POLARITY = 8'h08;
  localparam logic [7:0] ADDR_PULL_ENABLE = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h14;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h18;
  localparam int BIT_MODE = 0;
  localparam int BIT_IE = 1;
  localparam int BIT_ACK = 2;
  localparam int BIT_FLAG = 3;
  localparam int EV_FLAG_SET = 0;
  localparam int EV_ACK_REFUSED = 1;
  localparam int NUM_EV = 2;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [7:0] RST_BYTE = 8'h00;
endpackage

// ==== pin_irq_unit.sv ====
// Keyboard pin interrupt unit with AHB-Lite register slave
module pin_irq_unit
  import pin_irq_pkg::*;
#(
  parameter int NPINS = 8
)(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [NPINS-1:0] pinIn,
  output logic [NPINS-1:0] pullUpEn,
  output logic [NPINS-1:0] pullDownEn,
  output logic pinIrq,
  output logic sysIrq
);
  // ==========================================
  // State
  typedef struct packed {
    logic [NPINS-1:0] syncA;
    logic [NPINS-1:0] syncB;
    logic [NPINS-1:0] prev;
    logic [NPINS-1:0] pinEnable;
    logic [NPINS-1:0] polarity;
    logic [NPINS-1:0] pullEnable;
    logic mode;
    logic irqEnable;
    logic flag;
    logic armed;
    logic [NUM_EV-1:0] evStatus;
    logic [NUM_EV-1:0] evEnable;
    logic wrPend;
    logic rdPend;
    logic [7:0] addr;
    logic [31:0] rdata;
    logic [NPINS-1:0] pullUpQ;
    logic [NPINS-1:0] pullDnQ;
  } pirq_state_type;

  pirq_state_type st_r;
  pirq_state_type st_nxt;

  function automatic logic [NPINS-1:0] asserted(
    input logic [NPINS-1:0] lvl,
    input logic [NPINS-1:0] pol,
    input logic [NPINS-1:0] en
  );
    // Level equal to polarity bit counts as asserted
    asserted = ~(lvl ^ pol) & en;
  endfunction

  function automatic logic [31:0] byteWord(input logic [7:0] b);
    byteWord = {24'h000000, b};
  endfunction

  logic [NPINS-1:0] curAsserted;
  logic [NPINS-1:0] prevAsserted;
  logic [NPINS-1:0] edgeSeen;
  logic anyAsserted;
  logic detectEvt;
  logic ackWr;
  logic addrPhase;
  logic [7:0] wb;

  // ==========================================
  // Detection and registers
  always_comb
  begin
    st_nxt = st_r;
    wb = hwdata[7:0];
    st_nxt.syncA = pinIn;
    st_nxt.syncB = st_r.syncA;
    st_nxt.prev = st_r.syncB;
    // RULE1 RULE2 per-pin qualify
    curAsserted = asserted(st_r.syncB, st_r.polarity, st_r.pinEnable);
    prevAsserted = asserted(st_r.prev, st_r.polarity, st_r.pinEnable);
    // RULE4 RULE5 two-sample edge
    edgeSeen = curAsserted & ~prevAsserted;
    anyAsserted = |curAsserted;
    // RULE6 re-arm only when idle
    st_nxt.armed = ~anyAsserted;
    // RULE3 RULE17 RULE7 RULE10 mode select
    // RULE13 no masking on enable
    detectEvt = (st_r.armed && (|edgeSeen)) || (st_r.mode && anyAsserted);
    addrPhase = hsel && hready && htrans == HTRANS_NONSEQ;
    ackWr = st_r.wrPend && st_r.addr == ADDR_STATUS_CONTROL && wb[BIT_ACK];
    // RULE9 RULE11 guarded clear
    if (ackWr && !(st_r.mode && anyAsserted))
    begin
      st_nxt.flag = 1'b0;
    end
    // RULE19 set wins over clear
    if (detectEvt)
    begin
      st_nxt.flag = 1'b1;
    end
    if (detectEvt && !st_r.flag)
    begin
      st_nxt.evStatus[EV_FLAG_SET] = 1'b1;
    end
    if (ackWr && st_r.mode && anyAsserted)
    begin
      st_nxt.evStatus[EV_ACK_REFUSED] = 1'b1;
    end
    st_nxt.wrPend = addrPhase && hwrite;
    st_nxt.rdPend = addrPhase && !hwrite;
    if (addrPhase)
    begin
      st_nxt.addr = haddr[7:0];
    end
    if (st_r.wrPend)
    begin
      case (st_r.addr)
        ADDR_STATUS_CONTROL:
        begin
          // RULE16 flag not writable
          st_nxt.mode = wb[BIT_MODE];
          st_nxt.irqEnable = wb[BIT_IE];
        end
        // RULE15 independent enables
        ADDR_PIN_ENABLE: st_nxt.pinEnable = wb[NPINS-1:0];
        ADDR_POLARITY: st_nxt.polarity = wb[NPINS-1:0];
        ADDR_PULL_ENABLE: st_nxt.pullEnable = wb[NPINS-1:0];
        ADDR_IRQ_ENABLE: st_nxt.evEnable = wb[NUM_EV-1:0];
        ADDR_IRQ_CLEAR:
        begin
          // Set in same cycle wins only for a bit that was clear
          st_nxt.evStatus = (st_r.evStatus & ~wb[NUM_EV-1:0])
            | (st_nxt.evStatus & ~st_r.evStatus);
        end
        default: st_nxt.mode = st_nxt.mode;
      endcase
    end
    st_nxt.rdata = 32'h00000000;
    if (addrPhase && !hwrite)
    begin
      case (haddr[7:0])
        // RULE16 RULE18 ack and top read 0
        ADDR_STATUS_CONTROL: st_nxt.rdata = byteWord({4'h0, st_r.flag, 1'b0,
          st_r.irqEnable, st_r.mode});
        ADDR_PIN_ENABLE: st_nxt.rdata = byteWord(st_r.pinEnable);
        ADDR_POLARITY: st_nxt.rdata = byteWord(st_r.polarity);
        ADDR_PULL_ENABLE: st_nxt.rdata = byteWord(st_r.pullEnable);
        ADDR_IRQ_STATUS: st_nxt.rdata = {30'h0, st_r.evStatus};
        ADDR_IRQ_ENABLE: st_nxt.rdata = {30'h0, st_r.evEnable};
        default: st_nxt.rdata = 32'h00000000;
      endcase
    end
    // RULE12 pull direction from polarity
    st_nxt.pullUpQ = st_r.pullEnable & ~st_r.polarity;
    st_nxt.pullDnQ = st_r.pullEnable & st_r.polarity;
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ==========================================
  // Outputs
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st_r.rdata;
  assign pullUpEn = st_r.pullUpQ;
  assign pullDownEn = st_r.pullDnQ;
  // RULE8 request gating
  assign pinIrq = st_r.flag & st_r.irqEnable;
  assign sysIrq = |(st_r.evStatus & st_r.evEnable);

  // ==========================================
  // Checks
  // RULE8 request follows flag and enable
  property p_req;
    @(posedge core_clk) disable iff (!rst_b)
    pinIrq == (st_r.flag && st_r.irqEnable);
  endproperty
  a_req: assert property (p_req) else $error("irq mismatch"); // RULE8

  property p_set;
    @(posedge core_clk) disable iff (!rst_b)
    detectEvt |=> st_r.flag;
  endproperty
  a_set: assert property (p_set) else $error("flag not set"); // RULE19

  property p_lvlhold;
    @(posedge core_clk) disable iff (!rst_b)
    (ackWr && st_r.mode && anyAsserted && st_r.flag) |=> st_r.flag;
  endproperty
  a_lvlhold: assert property (p_lvlhold) else $error("lvl cleared"); // RULE11

  property p_clr;
    @(posedge core_clk) disable iff (!rst_b)
    (ackWr && !anyAsserted && !detectEvt) |=> !st_r.flag;
  endproperty
  a_clr: assert property (p_clr) else $error("ack failed"); // RULE9

  property p_onlyack;
    @(posedge core_clk) disable iff (!rst_b)
    (st_r.flag && !ackWr) |=> st_r.flag;
  endproperty
  a_onlyack: assert property (p_onlyack) else $error("flag lost"); // RULE9

  property p_edge;
    @(posedge core_clk) disable iff (!rst_b)
    (!st_r.mode && !st_r.flag && !(st_r.armed && |edgeSeen)) |=> !st_r.flag;
  endproperty
  a_edge: assert property (p_edge) else $error("spurious set"); // RULE7

  property p_arm;
    @(posedge core_clk) disable iff (!rst_b)
    anyAsserted |=> !st_r.armed;
  endproperty
  a_arm: assert property (p_arm) else $error("armed early"); // RULE6

  property p_sc;
    @(posedge core_clk) disable iff (!rst_b)
    (st_r.rdPend && st_r.addr == ADDR_STATUS_CONTROL)
      |-> hrdata[7:4] == 4'h0 && !hrdata[BIT_ACK];
  endproperty
  a_sc: assert property (p_sc) else $error("bad read"); // RULE18

  property p_pull;
    @(posedge core_clk) disable iff (!rst_b)
    ##1 (pullUpEn & pullDownEn) == '0;
  endproperty
  a_pull: assert property (p_pull) else $error("both pulls"); // RULE12

  // ==========================================
  // Sequences
  sequence s_scWrite;
    st_r.wrPend && st_r.addr == ADDR_STATUS_CONTROL;
  endsequence

  sequence s_armedEdge;
    st_r.armed && (|edgeSeen);
  endsequence

  sequence s_ackHeld;
    ackWr && st_r.mode && anyAsserted;
  endsequence

  // ==========================================
  // Bus checks
  // Zero wait, always okay
  property p_okay;
    @(posedge core_clk) disable iff (!rst_b)
    hreadyout && !hresp;
  endproperty
  a_okay: assert property (p_okay) else $error("bus not ready");

  // Read data only in data phase
  property p_rdIdle;
    @(posedge core_clk) disable iff (!rst_b)
    !st_r.rdPend |-> hrdata == 32'h00000000;
  endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("stray read data");

  // RULE16 flag reads back
  property p_rdFlag;
    @(posedge core_clk) disable iff (!rst_b)
    (st_r.rdPend && st_r.addr == ADDR_STATUS_CONTROL)
      |-> hrdata[BIT_FLAG] == $past(st_r.flag);
  endproperty
  a_rdFlag: assert property (p_rdFlag) else $error("flag read"); // RULE16

  // RULE17 mode bit written
  property p_modeWr;
    @(posedge core_clk) disable iff (!rst_b)
    s_scWrite |=> st_r.mode == $past(hwdata[BIT_MODE]);
  endproperty
  a_modeWr: assert property (p_modeWr) else $error("mode write"); // RULE17

  // RULE8 enable bit written
  property p_ieWr;
    @(posedge core_clk) disable iff (!rst_b)
    s_scWrite |=> st_r.irqEnable == $past(hwdata[BIT_IE]);
  endproperty
  a_ieWr: assert property (p_ieWr) else $error("enable write"); // RULE8

  // RULE16 flag ignores writes
  property p_flagWr;
    @(posedge core_clk) disable iff (!rst_b)
    (st_r.wrPend && st_r.addr == ADDR_STATUS_CONTROL && !hwdata[BIT_ACK]
      && !detectEvt) |=> st_r.flag == $past(st_r.flag);
  endproperty
  a_flagWr: assert property (p_flagWr) else $error("flag written"); // RULE16

  // RULE15 pin enables written
  property p_pinEnWr;
    @(posedge core_clk) disable iff (!rst_b)
    (st_r.wrPend && st_r.addr == ADDR_PIN_ENABLE)
      |=> st_r.pinEnable == $past(hwdata[NPINS-1:0]);
  endproperty
  a_pinEnWr: assert property (p_pinEnWr) else $error("pin enable"); // RULE15

  // RULE2 polarity written
  property p_polWr;
    @(posedge core_clk) disable iff (!rst_b)
    (st_r.wrPend && st_r.addr == ADDR_POLARITY)
      |=> st_r.polarity == $past(hwdata[NPINS-1:0]);
  endproperty
  a_polWr: assert property (p_polWr) else $error("polarity write"); // RULE2

  // ==========================================
  // Detection checks
  // Second flop fed by first only
  property p_sync;
    @(posedge core_clk) disable iff (!rst_b)
    1'b1 |=> st_r.syncB == $past(st_r.syncA);
  endproperty
  a_sync: assert property (p_sync) else $error("sync chain");

  // RULE4 RULE5 edge needs change
  property p_edgeDir;
    @(posedge core_clk) disable iff (!rst_b)
    s_armedEdge |-> |((st_r.syncB ^ st_r.prev) & st_r.pinEnable);
  endproperty
  a_edgeDir: assert property (p_edgeDir) else $error("edge w/o change"); // RULE4 RULE5

  // RULE7 edge sets flag
  property p_edgeSet;
    @(posedge core_clk) disable iff (!rst_b)
    s_armedEdge |=> st_r.flag;
  endproperty
  a_edgeSet: assert property (p_edgeSet) else $error("edge lost"); // RULE7

  // RULE1 disabled pins silent
  property p_quiet;
    @(posedge core_clk) disable iff (!rst_b)
    (st_r.pinEnable == '0 && !st_r.flag) |=> !st_r.flag;
  endproperty
  a_quiet: assert property (p_quiet) else $error("disabled pin set"); // RULE1

  // RULE10 level sets flag
  property p_lvlSet;
    @(posedge core_clk) disable iff (!rst_b)
    (st_r.mode && anyAsserted) |=> st_r.flag;
  endproperty
  a_lvlSet: assert property (p_lvlSet) else $error("level lost"); // RULE10

  // RULE11 refused ack recorded
  property p_ackHeld;
    @(posedge core_clk) disable iff (!rst_b)
    s_ackHeld |=> st_r.evStatus[EV_ACK_REFUSED];
  endproperty
  a_ackHeld: assert property (p_ackHeld) else $error("refusal lost"); // RULE11

  // RULE7 rise of flag recorded
  property p_evSet;
    @(posedge core_clk) disable iff (!rst_b)
    (detectEvt && !st_r.flag) |=> st_r.evStatus[EV_FLAG_SET];
  endproperty
  a_evSet: assert property (p_evSet) else $error("event lost"); // RULE7

  // Event bit sticky until cleared
  property p_evSticky;
    @(posedge core_clk) disable iff (!rst_b)
    (st_r.evStatus[EV_FLAG_SET]
      && !(st_r.wrPend && st_r.addr == ADDR_IRQ_CLEAR))
      |=> st_r.evStatus[EV_FLAG_SET];
  endproperty
  a_evSticky: assert property (p_evSticky) else $error("event dropped");

  // RULE12 pull-up at polarity 0
  property p_pullUp;
    @(posedge core_clk) disable iff (!rst_b)
    1'b1 |=> pullUpEn == $past(st_r.pullEnable & ~st_r.polarity);
  endproperty
  a_pullUp: assert property (p_pullUp) else $error("pull-up wrong"); // RULE12
endmodule

// ==== kpi_keys.sv ====
// Key switch model standing on the far side of the pin inputs
// ==========================================================
// Key model
module kpi_keys (
  input wire logic core_clk,
  input wire logic [7:0] keyDown,
  input wire logic [7:0] keyLevel,
  input wire logic [7:0] pullUpEn,
  input wire logic [7:0] pullDownEn,
  output logic [7:0] pinIn
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] floatVal = 8'h55;
  // Open pins wander so no stale level hides a fault
  always @(posedge core_clk)
  begin
    floatVal <= ~floatVal;
  end
  always_comb
  begin
    for (int n = 0; n < 8; n++)
    begin
      if (keyDown[n])
        pinIn[n] = keyLevel[n];
      else if (pullUpEn[n])
        pinIn[n] = 1'b1;
      else if (pullDownEn[n])
        pinIn[n] = 1'b0;
      else
        pinIn[n] = floatVal[n];
    end
  end
endmodule

// ==== test_keyboard_pin_interrupt.sv ====
// Self-checking bench of the pin interrupt unit
module test_keyboard_pin_interrupt import pin_irq_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0, rst_b = 0, hsel = 0, hwrite = 0, hready;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, pinIrq, sysIrq;
  logic [7:0] pinIn, pullUpEn, pullDownEn, keyDown = 0, keyLevel = 0, pol;
  int seed = 34, errCount = 0, checksDone = 0, cycles = 0, i, j, k, m;
  assign hready = hreadyout;
  pin_irq_unit dut (.core_clk(core_clk), .rst_b(rst_b), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .pinIn(pinIn), .pullUpEn(pullUpEn),
    .pullDownEn(pullDownEn), .pinIrq(pinIrq), .sysIrq(sysIrq));
  kpi_keys keys (.core_clk(core_clk), .keyDown(keyDown),
    .keyLevel(keyLevel), .pullUpEn(pullUpEn), .pullDownEn(pullDownEn),
    .pinIn(pinIn));
  // ==========================================================
  // Clock, timeout and report
  initial
  begin
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      errCount++;
      conclude();
    end
  end
  task automatic conclude;
    $display("Checks %0d errors %0d", checksDone, errCount);
    if (errCount == 0 && checksDone > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    checksDone++;
    if (got !== exp)
    begin
      $display("Error at %0t exp %h got %h", $time, exp, got);
      errCount++;
    end
  endtask
  // ==========================================================
  // Bus cycles
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h0, d});
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 32'h0);
    chk({24'h0, exp}, q);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic key(input int n, input logic dn);
    @(posedge core_clk);
    keyDown[n] <= dn;
    settle(8);
  endtask
  // Expected status and control byte: flag, irq enable, mode
  function automatic logic [7:0] sc(input logic f, input logic e, int md);
    return {4'h0, f, 1'b0, e, md[0]};
  endfunction
  // ==========================================================
  // Scenarios
  initial
  begin
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    rdc(ADDR_STATUS_CONTROL, RST_BYTE);
    rdc(8'h1c, 8'h00);
    wr(ADDR_IRQ_ENABLE, 8'h01);
    repeat (4)
    begin
      pol = $random(seed);
      i = $unsigned($random(seed)) % 8;
      j = (i + 1) % 8;
      k = (i + 2) % 8;
      keyLevel <= pol;
      for (m = 0; m < 2; m++)
      begin
        wr(ADDR_STATUS_CONTROL, sc(0, 0, m));
        wr(ADDR_POLARITY, pol);
        wr(ADDR_PULL_ENABLE, 8'hff);
        wr(ADDR_PIN_ENABLE, 8'hff ^ (8'h01 << j));
        settle(8);
        wr(ADDR_STATUS_CONTROL, sc(0, 0, m) | 8'h04);
        wr(ADDR_IRQ_CLEAR, 8'h03);
        rdc(ADDR_PIN_ENABLE, 8'hff ^ (8'h01 << j));
        rdc(ADDR_STATUS_CONTROL, sc(0, 0, m));
        chk(pol, pullDownEn);
        chk({24'h0, ~pol}, pullUpEn);
        chk(0, hresp);
        key(j, 1'b1);
        rdc(ADDR_STATUS_CONTROL, sc(0, 0, m));
        key(j, 1'b0);
        key(i, 1'b1);
        rdc(ADDR_STATUS_CONTROL, sc(1, 0, m));
        chk(0, pinIrq);
        chk(1, sysIrq);
        // Masking the event hides it; clearing removes it
        wr(ADDR_IRQ_ENABLE, 8'h00);
        settle(2);
        chk(0, sysIrq);
        wr(ADDR_IRQ_ENABLE, 8'h01);
        wr(ADDR_IRQ_CLEAR, 8'h01);
        settle(2);
        chk(0, sysIrq);
        wr(ADDR_STATUS_CONTROL, sc(1, 1, m));
        settle(2);
        chk(1, pinIrq);
        // Ack while held: refused only in level mode
        wr(ADDR_STATUS_CONTROL, sc(0, 1, m) | 8'h04);
        rdc(ADDR_STATUS_CONTROL, sc(m, 1, m));
        rdc(ADDR_IRQ_STATUS, m ? 8'h02 : 8'h00);
        key(k, 1'b1);
        rdc(ADDR_STATUS_CONTROL, sc(m, 1, m));
        key(k, 1'b0);
        key(i, 1'b0);
        wr(ADDR_STATUS_CONTROL, sc(1, 1, m) | 8'h04);
        rdc(ADDR_STATUS_CONTROL, sc(0, 1, m));
        settle(2);
        chk(0, pinIrq);
      end
    end
    conclude();
  end
endmodule
